// *** spc_peer_slave.sv ***
/*
 Behavioural serial slave on the far side of the port in master mode.
 Assumes the bench resolves pin levels and tells it polarity, phase and
 bit order; it shifts one reply byte per chip-select frame.
*/
`default_nettype none
module spc_peer_slave (
    // Pins
    input  wire logic       sclk,
    input  wire logic       cs_n,
    input  wire logic       mosi,
    output var  logic       miso,
    // Settings and data
    input  wire logic       cpol,
    input  wire logic       cpha,
    input  wire logic       lsb,
    input  wire logic [7:0] reply,
    output var  logic [7:0] got
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [7:0] sh;
    logic       cs_q;
    int         n;
    // Select seen a little late: last clock edge and release coincide
    always @(cs_n) cs_q <= #1 cs_n;
    initial begin
        miso = 1'b0;
        got  = 8'h00;
        sh   = 8'h00;
        cs_q = 1'b1;
        n    = 0;
    end
    // First bit out at select only when data leads the clock
    always @(negedge cs_n) begin
        sh = reply;
        n  = 0;
        if (!cpha) miso = lsb ? sh[0] : sh[7];
    end
    // Released line shows the inverse, never a stale valid bit
    always @(posedge cs_n) begin
        miso = ~miso;
    end
    always @(sclk) begin
        if (!cs_q) begin
            if ((sclk != cpol) != cpha) begin
                got = lsb ? {mosi, got[7:1]} : {got[6:0], mosi};
            end else begin
                if (!cpha) n = n + 1;
                if (n < 8) miso = lsb ? sh[n] : sh[7-n];
                if (cpha) n = n + 1;
            end
        end
    end
endmodule // spc_peer_slave
`default_nettype wire

// *** spc_pkg.sv ***
/*
 Shared constants and types for the serial port control block.
 Assumes a 100 MHz system clock and a 5-bit byte address bus.
*/
`default_nettype none
package spc_pkg;
    localparam int ADDR_W = 5;
    localparam int DATA_W = 16;
    localparam logic [4:0] OFF_STATUS = 5'h00;
    localparam logic [4:0] OFF_RX     = 5'h04;
    localparam logic [4:0] OFF_TX     = 5'h08;
    localparam logic [4:0] OFF_DIV    = 5'h0C;
    localparam logic [4:0] OFF_CTRL   = 5'h10;
    localparam logic [15:0] CTRL_RST  = 16'h0000;
    localparam logic [7:0] DIV_RST    = 8'h00;
    localparam int B_MODE = 14;
    localparam int B_TFL  = 13;
    localparam int B_RFL  = 12;
    localparam int B_CONT = 11;
    localparam int B_LOOP = 10;
    localparam int B_SOE  = 9;
    localparam int B_ROW  = 8;
    localparam int B_ZEN  = 7;
    localparam int B_TRIG = 6;
    localparam int B_LSB  = 5;
    localparam int B_WOM  = 4;
    localparam int B_CPOL = 3;
    localparam int B_CPHA = 2;
    localparam int B_MST  = 1;
    localparam int B_EN   = 0;
    localparam logic [2:0] FIFO_FULL = 3'h4;
    localparam logic [3:0] BYTE_BITS = 4'h8;
    localparam logic [4:0] EDGE_LAST = 5'h0F;
    localparam logic [4:0] GAP_LAST  = 5'h01;
    localparam logic [7:0] FILL_ZERO = 8'h00;
    typedef enum logic [1:0] {SPC_IDLE, SPC_RUN, SPC_GAP} spc_mst_t;
    typedef struct packed {
        logic [15:0]     ctrl;
        logic [7:0]      div;
        logic [15:0]     rdata;
        logic [3:0][7:0] txf;
        logic [1:0]      txrp;
        logic [2:0]      txc;
        logic [3:0][7:0] rxf;
        logic [1:0]      rxrp;
        logic [2:0]      rxc;
        logic            ovf;
        logic            rxirq;
        logic            txirq;
        logic            unf;
        logic            ista;
        logic [7:0]      tsh;
        logic [7:0]      rsh;
        logic [7:0]      last;
        logic [3:0]      bits;
        logic            smp;
        logic [2:0]      txdone;
        spc_mst_t        st;
        logic [7:0]      dcnt;
        logic [4:0]      edg;
        logic            sclk_i;
        logic            start_req;
        logic [2:0]      sclk_sy;
        logic [2:0]      cs_sy;
        logic [1:0]      mosi_sy;
        logic [1:0]      miso_sy;
        logic            o_sclk;
        logic            o_sclk_oe_n;
        logic            o_cs_n;
        logic            o_cs_oe_n;
        logic            o_mosi;
        logic            o_mosi_oe_n;
        logic            o_miso;
        logic            o_miso_oe_n;
        logic            o_irq;
    } spc_state_t;
endpackage
`default_nettype wire

// *** spc_port_control.sv ***
/*
 Serial peripheral port: control register, 4-byte FIFOs, master clock
 generator and slave edge detector, all in one state struct.
 Assumes pins are resolved outside from out/oe_n triples and that the
 bus master follows single-cycle strobes with read data one cycle late.
*/
// Our own choices: the address-and-strobe port and the register addresses.
// Operation
// - Mode field sets tx/rx event thresholds at one to four bytes.
// - Tx flush empties tx FIFO and ignores writes while set.
// - Tx flush held high sends zero or the previous byte.
// - Rx flush empties rx FIFO, drops incoming bytes, raises no rx events.
// - Rx flush with read trigger: reading rx data still starts transfers.
// - Continuous master mode keeps chip select low until tx FIFO empty.
// - Non-continuous: single byte frames, one serial clock stall between.
// - Loopback feeds our own data output back into data input.
// - Slave data output drives only when drive enable set, else open drain.
// - Rx overflow with overwrite replaces newest byte, otherwise drops it.
// - Empty tx FIFO sends zero when zero fill set, else last byte.
// - Write trigger: tx write starts transfer, tx event only.
// - Read trigger: rx read starts transfer, rx event only.
// - Bit order bit selects LSB first both ways, else MSB first.
// - Wired-or mode drives data outputs open drain, pull-ups external.
// - Clock polarity bit sets serial clock idle level.
// - Phase bit puts clock pulse at start or end of bit.
// - Master select chooses master or slave and pin directions.
// - Port enable must be set for any transfer.
// - Peer must use the same clock polarity and phase.
// - Both FIFOs hold four bytes, levels reported as three-bit counts.
// - Byte into full rx FIFO sets overflow, event unless rx flush.
`default_nettype none
module spc_port_control (
    // System
    input  wire logic                        clk_sys,
    input  wire logic                        rst_n,
    // Register port
    input  wire logic [spc_pkg::ADDR_W-1:0]  addr,
    input  wire logic [spc_pkg::DATA_W-1:0]  wdata,
    input  wire logic                        wr_en,
    input  wire logic                        rd_en,
    output logic      [spc_pkg::DATA_W-1:0]  rdata,
    // Serial clock pin
    input  wire logic                        sclk_in,
    output logic                             sclk_out,
    output logic                             sclk_oe_n,
    // Chip select pin
    input  wire logic                        cs_n_in,
    output logic                             cs_n_out,
    output logic                             cs_oe_n,
    // Data pins
    input  wire logic                        mosi_in,
    output logic                             mosi_out,
    output logic                             mosi_oe_n,
    input  wire logic                        miso_in,
    output logic                             miso_out,
    output logic                             miso_oe_n,
    // Event level
    output logic                             spi_event
);
    import spc_pkg::*;

    spc_state_t s_reg;
    spc_state_t s_next;

    always_comb begin
        logic en, mst, cpha, cpol, lsb, wom, od;
        logic lead, trail, samp, shft, din, dout, go, cont_go;
        logic push, load, bit_n;
        logic [7:0] rb;
        logic [2:0] thr;
        logic [1:0] wi;
        s_next  = s_reg;
        samp    = 1'b0;
        shft    = 1'b0;
        din     = 1'b0;
        rb      = 8'h00;
        en      = s_reg.ctrl[B_EN];
        mst     = s_reg.ctrl[B_MST];
        cpha    = s_reg.ctrl[B_CPHA];
        cpol    = s_reg.ctrl[B_CPOL];
        lsb     = s_reg.ctrl[B_LSB];
        wom     = s_reg.ctrl[B_WOM];
        od      = 1'b0;
        thr     = {1'b0, s_reg.ctrl[B_MODE+1:B_MODE]} + 3'h1;
        dout    = lsb ? s_reg.tsh[0] : s_reg.tsh[7];
        cont_go = s_reg.ctrl[B_CONT] && s_reg.txc != 3'h0
                  && !s_reg.ctrl[B_TFL];
        lead    = 1'b0;
        trail   = 1'b0;
        push    = 1'b0;
        load    = 1'b0;
        go      = 1'b0;
        bit_n   = 1'b0;
        wi      = 2'h0;
        // Only stages 1 and 2 of the clock and select chains, stage 1 of the data chains, are read
        s_next.sclk_sy = {s_reg.sclk_sy[1:0], sclk_in};
        s_next.cs_sy   = {s_reg.cs_sy[1:0], cs_n_in};
        s_next.mosi_sy = {s_reg.mosi_sy[0], mosi_in};
        s_next.miso_sy = {s_reg.miso_sy[0], miso_in};
        if (s_reg.ctrl[B_LOOP])
            din = dout;
        else
            din = mst ? s_reg.miso_sy[1] : s_reg.mosi_sy[1];
        rb = lsb ? {din, s_reg.rsh[7:1]} : {s_reg.rsh[6:0], din};

        // Register reads; sticky clears lose to later sets
        s_next.rdata = '0;
        if (rd_en) begin
            case (addr)
                OFF_STATUS: begin
                    s_next.rdata = {4'h0, s_reg.rxc > thr, s_reg.rxc,
                                    s_reg.ovf, s_reg.rxirq, s_reg.txirq,
                                    s_reg.unf, s_reg.txc, s_reg.ista};
                    s_next.ovf   = 1'b0;
                    s_next.rxirq = 1'b0;
                    s_next.txirq = 1'b0;
                    s_next.unf   = 1'b0;
                    s_next.ista  = 1'b0;
                end
                OFF_RX: begin
                    s_next.rdata = {8'h00, s_reg.rxf[s_reg.rxrp]};
                    if (s_reg.rxc != 3'h0) begin
                        s_next.rxrp = s_reg.rxrp + 2'h1;
                        s_next.rxc  = s_reg.rxc - 3'h1;
                    end
                    if (!s_reg.ctrl[B_TRIG])
                        s_next.start_req = 1'b1;
                end
                OFF_DIV:  s_next.rdata = {8'h00, s_reg.div};
                OFF_CTRL: s_next.rdata = s_reg.ctrl;
                default:  s_next.rdata = '0;
            endcase
        end
        if (wr_en) begin
            case (addr)
                OFF_TX: begin
                    if (!s_reg.ctrl[B_TFL] && s_reg.txc != FIFO_FULL) begin
                        wi = s_reg.txrp + s_reg.txc[1:0];
                        s_next.txf[wi] = wdata[7:0];
                        s_next.txc = s_reg.txc + 3'h1;
                    end
                end
                OFF_DIV:  s_next.div  = wdata[7:0];
                OFF_CTRL: s_next.ctrl = wdata;
                default: ;
            endcase
        end

        // Master clock generator
        case (s_reg.st)
            SPC_IDLE: begin
                s_next.sclk_i = cpol;
                s_next.dcnt   = 8'h00;
                s_next.edg    = 5'h00;
                if (s_reg.ctrl[B_TRIG])
                    go = s_reg.txc != 3'h0;
                else
                    go = s_reg.start_req;
                if (en && mst && go) begin
                    s_next.st        = SPC_RUN;
                    s_next.start_req = 1'b0;
                    load             = 1'b1;
                end
            end
            SPC_RUN: begin
                if (s_reg.dcnt == s_reg.div) begin
                    s_next.dcnt   = 8'h00;
                    s_next.sclk_i = ~s_reg.sclk_i;
                    s_next.edg    = s_reg.edg + 5'h01;
                    lead          = ~s_reg.edg[0];
                    trail         = s_reg.edg[0];
                    if (s_reg.edg == EDGE_LAST) begin
                        s_next.edg = 5'h00;
                        if (!cont_go)
                            s_next.st = SPC_GAP;
                    end
                end else begin
                    s_next.dcnt = s_reg.dcnt + 8'h01;
                end
                if (!en || !mst)
                    s_next.st = SPC_IDLE;
            end
            SPC_GAP: begin
                // Chip select high for one full serial clock
                s_next.sclk_i = cpol;
                if (s_reg.dcnt == s_reg.div) begin
                    s_next.dcnt = 8'h00;
                    s_next.edg  = s_reg.edg + 5'h01;
                    if (s_reg.edg == GAP_LAST)
                        s_next.st = SPC_IDLE;
                end else begin
                    s_next.dcnt = s_reg.dcnt + 8'h01;
                end
                if (!en || !mst)
                    s_next.st = SPC_IDLE;
            end
            default: s_next.st = SPC_IDLE;
        endcase

        // Slave edge detection on synchronised pins
        if (en && !mst && !s_reg.cs_sy[1]) begin
            if (s_reg.cs_sy[2]) begin
                load = 1'b1;
            end else begin
                lead  = s_reg.sclk_sy[2] == cpol && s_reg.sclk_sy[1] != cpol;
                trail = s_reg.sclk_sy[2] != cpol && s_reg.sclk_sy[1] == cpol;
            end
        end

        // Shared bit engine; phase picks which edge samples
        samp = cpha ? trail : lead;
        shft = cpha ? lead : trail;
        if (samp) begin
            s_next.rsh  = rb;
            s_next.smp  = 1'b1;
            s_next.bits = s_reg.bits + 4'h1;
            if (s_reg.bits == BYTE_BITS - 4'h1)
                push = 1'b1;
        end
        if (shft) begin
            if (s_reg.bits == BYTE_BITS) begin
                if (!mst || cont_go)
                    load = 1'b1;
            end else if (s_reg.smp) begin
                s_next.tsh = lsb ? s_reg.tsh >> 1 : s_reg.tsh << 1;
            end
        end
        if (load) begin
            s_next.bits = 4'h0;
            s_next.smp  = 1'b0;
            if (s_next.txc != 3'h0 && !s_reg.ctrl[B_TFL]) begin
                s_next.tsh  = s_next.txf[s_next.txrp];
                s_next.last = s_next.txf[s_next.txrp];
                s_next.txrp = s_next.txrp + 2'h1;
                s_next.txc  = s_next.txc - 3'h1;
            end else begin
                // Fill byte keeps the link clocking on underrun
                s_next.tsh = s_reg.ctrl[B_ZEN] ? FILL_ZERO : s_reg.last;
                s_next.unf = 1'b1;
                if (!s_reg.ctrl[B_TFL])
                    s_next.ista = 1'b1;
            end
        end
        if (push) begin
            if (s_reg.ctrl[B_TRIG]) begin
                s_next.txdone = s_reg.txdone + 3'h1;
                if (s_reg.txdone + 3'h1 >= thr) begin
                    s_next.txdone = 3'h0;
                    s_next.txirq  = 1'b1;
                    s_next.ista   = 1'b1;
                end
            end
            if (!s_reg.ctrl[B_RFL]) begin
                if (s_next.rxc == FIFO_FULL) begin
                    s_next.ovf  = 1'b1;
                    s_next.ista = 1'b1;
                    if (s_reg.ctrl[B_ROW])
                        s_next.rxf[s_next.rxrp + 2'h3] = rb;
                end else begin
                    wi = s_next.rxrp + s_next.rxc[1:0];
                    s_next.rxf[wi] = rb;
                    s_next.rxc = s_next.rxc + 3'h1;
                    if (!s_reg.ctrl[B_TRIG] && s_next.rxc >= thr) begin
                        s_next.rxirq = 1'b1;
                        s_next.ista  = 1'b1;
                    end
                end
            end
        end
        if (s_reg.ctrl[B_TFL])
            s_next.txc = 3'h0;
        if (s_reg.ctrl[B_RFL])
            s_next.rxc = 3'h0;

        // Registered pin drive
        bit_n = lsb ? s_next.tsh[0] : s_next.tsh[7];
        s_next.o_sclk = (en && mst && s_next.st == SPC_RUN) ?
                        s_next.sclk_i : cpol;
        s_next.o_sclk_oe_n = !(en && mst);
        s_next.o_cs_n      = !(en && mst && s_next.st == SPC_RUN);
        s_next.o_cs_oe_n   = !(en && mst);
        s_next.o_mosi      = wom ? 1'b0 : bit_n;
        s_next.o_mosi_oe_n = !(en && mst && (!wom || !bit_n));
        od = wom || !s_reg.ctrl[B_SOE];
        s_next.o_miso      = od ? 1'b0 : bit_n;
        s_next.o_miso_oe_n = !(en && !mst && !s_reg.cs_sy[1]
                               && (!od || !bit_n));
        s_next.o_irq = s_next.ista;
    end

    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            s_reg             <= '0;
            s_reg.ctrl        <= CTRL_RST;
            s_reg.div         <= DIV_RST;
            s_reg.o_sclk_oe_n <= 1'b1;
            s_reg.o_cs_n      <= 1'b1;
            s_reg.o_cs_oe_n   <= 1'b1;
            s_reg.o_mosi_oe_n <= 1'b1;
            s_reg.o_miso_oe_n <= 1'b1;
            s_reg.cs_sy       <= 3'h7;
        end else begin
            s_reg <= s_next;
        end
    end

    assign rdata     = s_reg.rdata;
    assign sclk_out  = s_reg.o_sclk;
    assign sclk_oe_n = s_reg.o_sclk_oe_n;
    assign cs_n_out  = s_reg.o_cs_n;
    assign cs_oe_n   = s_reg.o_cs_oe_n;
    assign mosi_out  = s_reg.o_mosi;
    assign mosi_oe_n = s_reg.o_mosi_oe_n;
    assign miso_out  = s_reg.o_miso;
    assign miso_oe_n = s_reg.o_miso_oe_n;
    assign spi_event = s_reg.o_irq;

    // Helper view of edge events for the overflow check
    logic lead_q;
    logic trail_q;
    assign lead_q  = s_reg.st == SPC_RUN && s_reg.dcnt == s_reg.div
                     && !s_reg.edg[0] && s_reg.ctrl[B_MST];
    assign trail_q = s_reg.st == SPC_RUN && s_reg.dcnt == s_reg.div
                     && s_reg.edg[0] && s_reg.ctrl[B_MST];

    // Slave leaves clock, select and master data undriven
    slave_pins_off_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
        !s_reg.ctrl[B_MST] |=> sclk_oe_n && cs_oe_n && mosi_oe_n)
        else $error("master pins driven in slave mode");
    // Read data stands one cycle only
    rdata_idle_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
        !rd_en |=> rdata == '0)
        else $error("read data not zero outside read");
    fifo_bound_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
        s_reg.rxc <= FIFO_FULL && s_reg.txc <= FIFO_FULL)
        else $error("FIFO count above four");

    tx_flush_empty_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
        s_reg.ctrl[B_TFL] |=> s_reg.txc == 3'h0)
        else $error("tx FIFO not emptied under flush");
    rx_flush_empty_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
        s_reg.ctrl[B_RFL] |=> s_reg.rxc == 3'h0 && !$rose(s_reg.rxirq))
        else $error("rx FIFO not emptied under flush");
    idle_clock_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
        !s_reg.ctrl[B_EN] |=> sclk_out == $past(s_reg.ctrl[B_CPOL]))
        else $error("serial clock not at idle level");
    cs_released_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
        !s_reg.ctrl[B_EN] |=> cs_n_out && s_reg.st == SPC_IDLE)
        else $error("chip select low while disabled");
    miso_open_drain_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
        !s_reg.ctrl[B_SOE] |=> miso_oe_n || !miso_out)
        else $error("slave output driven high without enable");
    mosi_wired_or_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
        s_reg.ctrl[B_WOM] |=> mosi_oe_n || !mosi_out)
        else $error("data output driven high in wired-or mode");
    rx_overflow_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
        s_reg.rxc == FIFO_FULL && !rd_en && !s_reg.ctrl[B_RFL]
        && (s_reg.ctrl[B_CPHA] ? trail_q : lead_q) && s_reg.bits == 4'h7
        |=> s_reg.ovf && s_reg.rxc == FIFO_FULL)
        else $error("overflow not flagged on full rx FIFO");
    gap_cs_high_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
        s_reg.st == SPC_RUN ##1 s_reg.st == SPC_GAP |-> cs_n_out)
        else $error("chip select low during stall");
endmodule // spc_port_control
`default_nettype wire

// *** spc_port_control_bench.sv ***
/*
 Self-checking bench for the serial port control block in master mode.
 Assumes the peer model in its own file; pins are resolved here with
 pull-ups on chip select and mosi; miso carries the peer output when undriven.
*/
`default_nettype none
module spc_port_control_bench;
    timeunit 1ns;
    timeprecision 1ps;
    import spc_pkg::*;
    logic        clk_sys, rst_n, wr_en, rd_en, pc, ph, pl;
    logic [4:0]  addr;
    logic [15:0] wdata, rdata, rv;
    logic [7:0]  reply, got;
    logic        sclk_out, sclk_oe_n, cs_n_out, cs_oe_n, mosi_out;
    logic        mosi_oe_n, miso_out, miso_oe_n, spi_event, peer_miso;
    int          error_cnt, checks, cyc, cs_rise;
    localparam logic [15:0] M_BASE = 16'h0043;
    wire sclk_w = sclk_oe_n ? pc : sclk_out;
    wire cs_w   = cs_oe_n ? 1'b1 : cs_n_out;
    wire mosi_w = mosi_oe_n ? 1'b1 : mosi_out;
    wire miso_w = miso_oe_n ? peer_miso : miso_out;
    spc_port_control i_spc_port_control (
        .clk_sys(clk_sys), .rst_n(rst_n), .addr(addr), .wdata(wdata),
        .wr_en(wr_en), .rd_en(rd_en), .rdata(rdata), .sclk_in(sclk_w),
        .sclk_out(sclk_out), .sclk_oe_n(sclk_oe_n), .cs_n_in(cs_w),
        .cs_n_out(cs_n_out), .cs_oe_n(cs_oe_n), .mosi_in(mosi_w),
        .mosi_out(mosi_out), .mosi_oe_n(mosi_oe_n), .miso_in(miso_w),
        .miso_out(miso_out), .miso_oe_n(miso_oe_n), .spi_event(spi_event));
    spc_peer_slave i_spc_peer_slave (
        .sclk(sclk_w), .cs_n(cs_w), .mosi(mosi_w), .miso(peer_miso),
        .cpol(pc), .cpha(ph), .lsb(pl), .reply(reply), .got(got));
    function automatic logic [15:0] bm(input int b);
        return 16'h0001 << b;
    endfunction
    task automatic final_report();
        if (error_cnt == 0 && checks > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask
    task automatic chk(input logic [15:0] seen, exp, input string msg);
        checks++;
        if (seen !== exp) begin
            error_cnt++;
            $display("[FAIL] %0t %s: got %h want %h", $time, msg, seen, exp);
        end
    endtask
    task automatic wr(input logic [4:0] a, input logic [15:0] d);
        @(posedge clk_sys);
        addr  <= a;
        wdata <= d;
        wr_en <= 1'b1;
        @(posedge clk_sys);
        wr_en <= 1'b0;
        #1;
    endtask
    task automatic rd(input logic [4:0] a, output logic [15:0] d);
        @(posedge clk_sys);
        addr  <= a;
        rd_en <= 1'b1;
        @(posedge clk_sys);
        rd_en <= 1'b0;
        #1;
        d = rdata;
    endtask
    // Bounded wait for k frames to close, then let the line settle
    task automatic frames(input int k);
        int c;
        c = 0;
        while (cs_rise < k && c < 3000) begin
            @(posedge clk_sys);
            c++;
        end
        if (c >= 3000) begin
            error_cnt++;
            $display("[FAIL] %0t frame never closed", $time);
        end
        repeat (40) @(posedge clk_sys);
    endtask
    task automatic t_reset();
        rd(OFF_CTRL, rv);
        chk(rv, CTRL_RST, "control reset");
        rd(5'h14, rv);
        chk(rv, 16'h0000, "unmapped read");
        chk(cs_n_out, 1'b1, "cs idle when off");
        chk(sclk_oe_n, 1'b1, "clock undriven when off");
        chk(spi_event, 1'b0, "no event at reset");
    endtask
    task automatic t_mode3();
        pc = 1'b1; ph = 1'b1; pl = 1'b0; reply = 8'h3C;
        wr(OFF_DIV, 16'h0003);
        wr(OFF_CTRL, M_BASE | bm(B_CPOL) | bm(B_CPHA));
        rd(OFF_CTRL, rv);
        chk(rv, 16'h004F, "control readback");
        repeat (4) @(posedge clk_sys);
        chk(sclk_oe_n, 1'b0, "master drives clock");
        chk(sclk_out, 1'b1, "clock idles high");
        chk(miso_oe_n, 1'b1, "master leaves miso undriven");
        cs_rise = 0;
        wr(OFF_TX, 16'h00A5);
        frames(1);
        chk(got, 8'hA5, "mode 3 byte out");
        rd(OFF_RX, rv);
        chk(rv, 16'h003C, "mode 3 byte in");
        chk(sclk_out, 1'b1, "clock back idle");
    endtask
    task automatic t_lsb();
        pc = 1'b0; ph = 1'b0; pl = 1'b0; reply = 8'h12;
        wr(OFF_CTRL, M_BASE | bm(B_LSB));
        repeat (4) @(posedge clk_sys);
        chk(sclk_out, 1'b0, "clock idles low");
        cs_rise = 0;
        wr(OFF_TX, 16'h0001);
        frames(1);
        chk(got, 8'h80, "lsb first out");
        rd(OFF_RX, rv);
        chk(rv, 16'h0048, "lsb first in");
    endtask
    task automatic t_loop();
        reply = 8'hC3;
        wr(OFF_CTRL, M_BASE | bm(B_LOOP));
        cs_rise = 0;
        wr(OFF_TX, 16'h005A);
        frames(1);
        rd(OFF_RX, rv);
        chk(rv, 16'h005A, "loopback data");
    endtask
    task automatic t_flush();
        wr(OFF_CTRL, M_BASE | bm(B_TFL) | bm(B_ZEN));
        wr(OFF_TX, 16'h0077);
        rd(OFF_STATUS, rv);
        chk(rv[3:1], 3'h0, "tx write ignored in flush");
        reply = 8'h99;
        wr(OFF_CTRL, 16'h0003 | bm(B_ZEN) | bm(B_RFL));
        cs_rise = 0;
        rd(OFF_RX, rv);
        frames(1);
        chk(got, FILL_ZERO, "zero fill on empty tx");
        rd(OFF_STATUS, rv);
        chk(rv[10:8], 3'h0, "rx dropped in flush");
        chk(rv[6], 1'b0, "no rx event in flush");
        chk(cs_rise, 1, "read starts transfer in flush");
    endtask
    task automatic t_cont();
        reply = 8'h66;
        wr(OFF_CTRL, M_BASE | bm(B_CONT) | bm(B_MODE));
        rd(OFF_STATUS, rv);
        cs_rise = 0;
        wr(OFF_TX, 16'h0011);
        wr(OFF_TX, 16'h0022);
        wr(OFF_TX, 16'h0033);
        frames(1);
        repeat (100) @(posedge clk_sys);
        chk(cs_rise, 1, "one select across bytes");
        chk(got, 8'h33, "last chained byte");
        chk(spi_event, 1'b1, "tx event level");
        rd(OFF_STATUS, rv);
        chk(rv[5], 1'b1, "tx event at two bytes");
        chk(rv[11], 1'b1, "rx above threshold");
        chk(rv[10:8], 3'h3, "rx count three");
        wr(OFF_CTRL, M_BASE | bm(B_MODE));
        cs_rise = 0;
        wr(OFF_TX, 16'h0044);
        wr(OFF_TX, 16'h0055);
        wr(OFF_TX, 16'h0077);
        frames(3);
        chk(cs_rise, 3, "one frame per byte");
        rd(OFF_STATUS, rv);
        chk(rv[10:8], FIFO_FULL, "rx full at four");
        chk(rv[7], 1'b1, "overflow flagged");
        chk(rv[0], 1'b1, "overflow raises event");
    endtask
    initial begin
        clk_sys = 1'b0;
        forever #5 clk_sys = ~clk_sys;
    end
    always @(posedge cs_w) cs_rise++;
    // Ceiling well above the frames the scenarios need
    always @(posedge clk_sys) begin
        cyc++;
        if (cyc == 20000) begin
            error_cnt++;
            $display("[FAIL] %0t run did not finish", $time);
            final_report();
        end
    end
    initial begin
        rst_n = 1'b0; wr_en = 1'b0; rd_en = 1'b0; addr = 5'h00;
        wdata = 16'h0000; pc = 1'b0; ph = 1'b0; pl = 1'b0; reply = 8'h00;
        error_cnt = 0; checks = 0; cyc = 0; cs_rise = 0;
        repeat (10) @(posedge clk_sys);
        rst_n <= 1'b1;
        @(posedge clk_sys);
        t_reset();
        t_mode3();
        t_lsb();
        t_loop();
        t_flush();
        t_cont();
        final_report();
    end
endmodule // spc_port_control_bench
`default_nettype wire
